// file: src/sar_ctrl_pkg.sv
// Package: constants and carrier types for the successive-approximation control
package sar_ctrl_pkg;

  localparam int RESULT_WIDTH = 10;
  localparam int UPPER_WIDTH = 8;
  localparam int LOWER_WIDTH = 2;

  // Reset-acknowledge limit after the trigger's rising edge
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_ACK_MAX_NS = 1500;
  localparam int RESET_ACK_CYCLES = RESET_ACK_MAX_NS / CLK_PERIOD_NS;
  // Least trigger high width the host must keep
  localparam int TRIGGER_MIN_NS = 500;
  localparam int TRIGGER_MIN_CYCLES = (TRIGGER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Cycles the DAC is given to settle before each comparator decision
  localparam int SETTLE_CYCLES = 2;

  localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 10'h000;
  localparam logic [RESULT_WIDTH-1:0] MSB_ONLY = 10'h200;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ARMED = 4'b0010,
    ST_TRIAL = 4'b0100,
    ST_DONE = 4'b1000
  } sar_state_t;

  typedef struct packed {
    logic [UPPER_WIDTH-1:0] data;
    logic [UPPER_WIDTH-1:0] oe;
  } upper_bus_t;

  typedef struct packed {
    logic [LOWER_WIDTH-1:0] data;
    logic [LOWER_WIDTH-1:0] oe;
  } lower_bus_t;

endpackage : sar_ctrl_pkg

// file: src/pin_sync.sv
// Module: two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule : pin_sync
`default_nettype wire

// file: src/sar_adc_conversion_control.sv
// Module: 10-bit successive-approximation conversion control with byte outputs
// Function
// - On the trigger's rising edge the logic resets and the completion flag rises in 1.5 us.
// - Bit trials begin on the trigger's falling edge, not its rising edge.
// - The trials run through all ten bits from most to least significant.
// - Each trial sets its bit and clears it if the comparator says the DAC exceeds the input.
// - After the last bit is decided the completion flag goes low, result available.
// - Upper enable low drives the 8 upper bits, lower enable low the 2 lower, else released.
// - Range open gives offset binary (zero reads 10000000 00), tied low straight binary.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_control
  import sar_ctrl_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic CONVERT_TRIGGER,
  input wire logic DAC_ABOVE_INPUT,
  input wire logic RANGE_SELECT_OPEN,
  input wire logic upper_byte_out_en_n,
  input wire logic lower_byte_out_en_n,
  output logic [RESULT_WIDTH-1:0] DAC_CODE,
  output logic BIPOLAR_OFFSET_ON,
  output logic result_pending_n,
  output logic result_pending_n_oe,
  output logic [UPPER_WIDTH-1:0] UPPER_DATA,
  output logic [UPPER_WIDTH-1:0] UPPER_DATA_OE,
  output logic [LOWER_WIDTH-1:0] LOWER_DATA,
  output logic [LOWER_WIDTH-1:0] LOWER_DATA_OE
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [4:0] pins_sync;
  logic trig_s;
  logic cmp_s;
  logic range_s;
  logic upper_en_s_n;
  logic lower_en_s_n;

  // Enables idle high after reset through inversion around the sync
  pin_sync #(.WIDTH(5)) u_sync (
    .clk(CORE_CLK),
    .rst(RESET),
    .async_in({CONVERT_TRIGGER, DAC_ABOVE_INPUT, RANGE_SELECT_OPEN,
               ~upper_byte_out_en_n, ~lower_byte_out_en_n}),
    .sync_out(pins_sync)
  );

  assign trig_s = pins_sync[4];
  assign cmp_s = pins_sync[3];
  assign range_s = pins_sync[2];
  assign upper_en_s_n = ~pins_sync[1];
  assign lower_en_s_n = ~pins_sync[0];

  // ----------------------------------------
  // Trigger edge detection
  // ----------------------------------------
  logic trig_d_reg;
  logic trig_rise;
  logic trig_fall;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      trig_d_reg <= 1'b0;
    end else begin
      trig_d_reg <= trig_s;
    end
  end

  assign trig_rise = trig_s & ~trig_d_reg;
  assign trig_fall = ~trig_s & trig_d_reg;

  // ----------------------------------------
  // Trial resolution
  // ----------------------------------------
  // Drops the trial bit on overshoot and sets the next one down
  function automatic logic [RESULT_WIDTH-1:0] resolve_trial(
    input logic [RESULT_WIDTH-1:0] code,
    input logic [RESULT_WIDTH-1:0] trial,
    input logic above
  );
    logic [RESULT_WIDTH-1:0] kept;
    kept = above ? (code & ~trial) : code;
    return kept | (trial >> 1);
  endfunction : resolve_trial

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  sar_state_t state_reg;
  sar_state_t state_next;
  logic [RESULT_WIDTH-1:0] sar_reg;
  logic [RESULT_WIDTH-1:0] trial_bit_reg;
  logic [7:0] settle_reg;
  logic pending_n_reg;
  logic decide;
  logic last_decide;

  // Comparator reaches cmp_s two edges late, so each bit spends SETTLE + 2 cycles;
  // a shorter wait would judge the previous trial code
  assign decide = (state_reg == ST_TRIAL) && (settle_reg == 8'(SETTLE + 1));
  assign last_decide = decide && trial_bit_reg[0];

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // A fall with no rise before it is ignored
        if (trig_rise) begin
          state_next = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (trig_fall) begin
          state_next = ST_TRIAL;
        end
      end
      ST_TRIAL: begin
        if (trig_rise) begin
          state_next = ST_ARMED;
        end else if (last_decide) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        if (trig_rise) begin
          state_next = ST_ARMED;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Rising edge always restarts, even mid-conversion: a new trigger wins
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      sar_reg <= RESULT_RESET;
      trial_bit_reg <= RESULT_RESET;
    end else if (trig_rise) begin
      sar_reg <= RESULT_RESET;
      trial_bit_reg <= RESULT_RESET;
    end else if (state_reg == ST_ARMED && trig_fall) begin
      sar_reg <= MSB_ONLY;
      trial_bit_reg <= MSB_ONLY;
    end else if (decide) begin
      sar_reg <= resolve_trial(sar_reg, trial_bit_reg, cmp_s);
      trial_bit_reg <= trial_bit_reg >> 1;
    end else if (state_reg == ST_DONE) begin
      // Result frozen so repeated byte reads agree
      sar_reg <= sar_reg;
    end
  end

  // Eight bits cap SETTLE at 254
  always_ff @(posedge CORE_CLK) begin
    if (RESET || state_reg != ST_TRIAL || decide) begin
      settle_reg <= 8'h00;
    end else begin
      settle_reg <= settle_reg + 8'h01;
    end
  end

  // ----------------------------------------
  // Completion flag
  // ----------------------------------------
  // High one edge after the synchronised rise, well inside the limit
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      pending_n_reg <= 1'b0;
    end else if (trig_rise) begin
      pending_n_reg <= 1'b1;
    end else if (last_decide) begin
      pending_n_reg <= 1'b0;
    end
  end

  // Open-collector style: only pull low, released high otherwise
  assign result_pending_n = 1'b0;
  assign result_pending_n_oe = ~pending_n_reg;

  assign DAC_CODE = sar_reg;
  assign BIPOLAR_OFFSET_ON = range_s;

  // ----------------------------------------
  // Byte output buffers
  // ----------------------------------------
  upper_bus_t upper_reg;
  lower_bus_t lower_reg;

  // Data lags the result by one edge, settled long before any read
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      upper_reg <= '0;
      lower_reg <= '0;
    end else begin
      upper_reg.data <= sar_reg[RESULT_WIDTH-1 -: UPPER_WIDTH];
      upper_reg.oe <= {UPPER_WIDTH{~upper_en_s_n}};
      lower_reg.data <= sar_reg[LOWER_WIDTH-1:0];
      lower_reg.oe <= {LOWER_WIDTH{~lower_en_s_n}};
    end
  end

  assign UPPER_DATA = upper_reg.data;
  assign UPPER_DATA_OE = upper_reg.oe;
  assign LOWER_DATA = lower_reg.data;
  assign LOWER_DATA_OE = lower_reg.oe;

endmodule : sar_adc_conversion_control
`default_nettype wire

// file: verif/sar_ctrl_props.sv
// Checker: timing and output relations of the conversion control
`timescale 1ns/1ps
`default_nettype none
module sar_ctrl_props
  import sar_ctrl_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic CONVERT_TRIGGER,
  input wire logic RANGE_SELECT_OPEN,
  input wire logic upper_byte_out_en_n,
  input wire logic lower_byte_out_en_n,
  input wire logic [RESULT_WIDTH-1:0] DAC_CODE,
  input wire logic BIPOLAR_OFFSET_ON,
  input wire logic result_pending_n_oe,
  input wire logic [UPPER_WIDTH-1:0] UPPER_DATA,
  input wire logic [UPPER_WIDTH-1:0] UPPER_DATA_OE,
  input wire logic [LOWER_WIDTH-1:0] LOWER_DATA,
  input wire logic [LOWER_WIDTH-1:0] LOWER_DATA_OE
);
  // Fall to done: sync and arm edges, then ten bits of SETTLE + 2 cycles each
  localparam int DONE_MAX = 6 + 10 * (SETTLE + 2);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  a_flag_release: assert property ($rose(CONVERT_TRIGGER) |->
    ##[1:15] !result_pending_n_oe)
    else $error("flag not released after trigger rise");
  a_trials_late: assert property ($rose(CONVERT_TRIGGER) ##1 CONVERT_TRIGGER [*4]
    |-> DAC_CODE == 10'h000)
    else $error("trials started while trigger high");
  a_msb_first: assert property ($fell(CONVERT_TRIGGER) |-> ##[1:6] DAC_CODE == MSB_ONLY)
    else $error("first trial code not msb only");
  a_done_bound: assert property ($fell(CONVERT_TRIGGER) |->
    ##[3:DONE_MAX] (result_pending_n_oe || CONVERT_TRIGGER))
    else $error("conversion did not complete in time");
  a_result_held: assert property (result_pending_n_oe && $past(result_pending_n_oe)
    && !CONVERT_TRIGGER |-> $stable(DAC_CODE))
    else $error("result changed while held");
  a_upper_on: assert property (!upper_byte_out_en_n [*5] |-> UPPER_DATA_OE == 8'hff)
    else $error("upper buffer not driving");
  a_lower_off: assert property (lower_byte_out_en_n [*5] |-> LOWER_DATA_OE == 2'h0)
    else $error("lower buffer not released");
  a_word_match: assert property (result_pending_n_oe [*3] ##1
    (result_pending_n_oe && UPPER_DATA_OE[0] && LOWER_DATA_OE[0])
    |-> {UPPER_DATA, LOWER_DATA} == DAC_CODE)
    else $error("byte outputs differ from result");
  a_range_follow: assert property ($stable(RANGE_SELECT_OPEN) [*6]
    |-> BIPOLAR_OFFSET_ON == RANGE_SELECT_OPEN)
    else $error("offset switch does not follow range pin");
endmodule : sar_ctrl_props
bind sar_adc_conversion_control sar_ctrl_props #(.SETTLE(SETTLE)) u_sar_ctrl_props (
  .CORE_CLK(CORE_CLK), .RESET(RESET), .CONVERT_TRIGGER(CONVERT_TRIGGER),
  .RANGE_SELECT_OPEN(RANGE_SELECT_OPEN), .upper_byte_out_en_n(upper_byte_out_en_n),
  .lower_byte_out_en_n(lower_byte_out_en_n), .DAC_CODE(DAC_CODE),
  .BIPOLAR_OFFSET_ON(BIPOLAR_OFFSET_ON), .result_pending_n_oe(result_pending_n_oe),
  .UPPER_DATA(UPPER_DATA), .UPPER_DATA_OE(UPPER_DATA_OE), .LOWER_DATA(LOWER_DATA),
  .LOWER_DATA_OE(LOWER_DATA_OE));
`default_nettype wire

// file: verif/analog_front_model.sv
// Comparator model: DAC code against a held input level
`timescale 1ns/1ps
`default_nettype none
module analog_front_model
  import sar_ctrl_pkg::*;
(
  input wire logic [RESULT_WIDTH-1:0] dac_code,
  input wire logic [RESULT_WIDTH-1:0] level,
  output logic dac_above_input
);
  // Settles at once; the block's synchroniser supplies the decision delay
  assign dac_above_input = (dac_code > level);
endmodule : analog_front_model
`default_nettype wire

// file: verif/test_sar_adc_conversion_control.sv
// Self-checking bench for the conversion control
`timescale 1ns/1ps
`default_nettype none
module test_sar_adc_conversion_control;
  import sar_ctrl_pkg::*;
  logic clk = 1'b0, rst = 1'b1, trig = 1'b0, rng = 1'b0, ue_n = 1'b1, le_n = 1'b1;
  logic above, bip, pend_n, pend_oe, flag;
  logic [9:0] lvl = 10'h000, code;
  logic [7:0] up, up_oe;
  logic [1:0] lo, lo_oe;
  int n_mismatch = 0, compares = 0, cycles = 0;
  always #50 clk = ~clk;
  // Open-drain flag with pull-up
  assign flag = pend_oe ? pend_n : 1'b1;
  analog_front_model u_analog_front_model (.dac_code(code), .level(lvl), .dac_above_input(above));
  sar_adc_conversion_control u_sar_adc_conversion_control (.CORE_CLK(clk), .RESET(rst),
    .CONVERT_TRIGGER(trig), .DAC_ABOVE_INPUT(above), .RANGE_SELECT_OPEN(rng),
    .upper_byte_out_en_n(ue_n), .lower_byte_out_en_n(le_n), .DAC_CODE(code),
    .BIPOLAR_OFFSET_ON(bip), .result_pending_n(pend_n), .result_pending_n_oe(pend_oe),
    .UPPER_DATA(up), .UPPER_DATA_OE(up_oe), .LOWER_DATA(lo), .LOWER_DATA_OE(lo_oe));
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rise(input logic [9:0] v);
    @(posedge clk);
    trig <= 1'b1;
    lvl <= v;
    repeat (8) @(negedge clk);
    chk("flag high", 10'h1, {9'h0, flag});
    chk("code held", 10'h0, code);
    @(posedge clk);
    trig <= 1'b0;
  endtask : rise
  task automatic convert(input logic [9:0] v);
    int i;
    i = 0;
    rise(v);
    while (flag !== 1'b0 && i < 60) begin
      @(negedge clk);
      i++;
    end
    chk("flag low", 10'h0, {9'h0, flag});
  endtask : convert
  task automatic read(input logic [9:0] exp, input logic u, input logic l);
    @(posedge clk);
    ue_n <= u;
    le_n <= l;
    repeat (5) @(negedge clk);
    chk("oe on", {{8{~u}}, {2{~l}}}, {up_oe, lo_oe});
    chk("word", exp & {{8{~u}}, {2{~l}}}, {up, lo} & {up_oe, lo_oe});
    @(posedge clk);
    ue_n <= 1'b1;
    le_n <= 1'b1;
    repeat (5) @(negedge clk);
    chk("oe off", 10'h0, {up_oe, lo_oe});
  endtask : read
  task automatic t_codes();
    logic [9:0] vals[5] = '{10'h3ff, 10'h000, 10'h155, 10'h2aa, 10'h201};
    foreach (vals[k]) begin
      convert(vals[k]);
      read(vals[k], 1'b0, 1'b0);
    end
    $display("t_codes done");
  endtask : t_codes
  task automatic t_split();
    convert(10'h1e6);
    read(10'h1e6, 1'b0, 1'b1);
    read(10'h1e6, 1'b1, 1'b0);
    read(10'h1e6, 1'b0, 1'b0);
    $display("t_split done");
  endtask : t_split
  task automatic t_restart();
    rise(10'h0f0);
    repeat (10) @(negedge clk);
    convert(10'h30c);
    read(10'h30c, 1'b0, 1'b0);
    $display("t_restart done");
  endtask : t_restart
  task automatic t_bipolar();
    @(posedge clk);
    rng <= 1'b1;
    convert(10'h200);
    chk("offset on", 10'h1, {9'h0, bip});
    read(10'h200, 1'b0, 1'b0);
    @(posedge clk);
    rng <= 1'b0;
    repeat (6) @(negedge clk);
    chk("offset off", 10'h0, {9'h0, bip});
    $display("t_bipolar done");
  endtask : t_bipolar
  task automatic wrap_up();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_codes();
    t_split();
    t_restart();
    t_bipolar();
    wrap_up();
  end
endmodule : test_sar_adc_conversion_control
`default_nettype wire
